// >>> mpr_consts.svh
// constants shared by both ends of the mesh packet link
`ifndef MPR_CONSTS_SVH
`define MPR_CONSTS_SVH
// ***************
// port indices
// ***************
`define MPR_P_EAST 3'h0
`define MPR_P_WEST 3'h1
`define MPR_P_NORTH 3'h2
`define MPR_P_SOUTH 3'h3
`define MPR_P_LOCAL 3'h4
// ***************
// packet layout
// ***************
`define MPR_HDR_BYTES 12'h008
`define MPR_B_COL 3'h0
`define MPR_B_ROW 3'h1
`define MPR_B_TAG 3'h2
`define MPR_B_LEN_LO 12'h004
`define MPR_B_LEN_HI 12'h005
`define MPR_HDR_LAST 3'h7
`define MPR_MAX_WORDS 10'h200
// ***************
// check code
// ***************
`define MPR_CRC_POLY 8'h07
`define MPR_CRC_INIT 8'h00
`endif

// >>> mpr_pkg.sv
// types and check-code step for the mesh packet router
`include "mpr_consts.svh"
package mpr_pkg;
    typedef enum logic [1:0] {
        IN_HDR = 2'b00,
        IN_REQ = 2'b01,
        IN_REPLAY = 2'b10,
        IN_BODY = 2'b11
    } mpr_in_state_t;

    typedef enum logic {
        TX_DATA = 1'b0,
        TX_CRC = 1'b1
    } mpr_tx_state_t;

    function automatic logic [7:0] mpr_crc_step(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc ^ d;
        for (int k = 0; k < 8; k++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ `MPR_CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction
endpackage

// >>> mpr_link_if.sv
// one bidirectional neighbour link between router and peer
`timescale 1ns/1ps
interface mpr_link_if;
    logic [7:0] r2p_data;
    logic r2p_valid;
    logic r2p_ack;
    logic [7:0] p2r_data;
    logic p2r_valid;
    logic p2r_ack;

    modport router_end (
        output r2p_data,
        output r2p_valid,
        input r2p_ack,
        input p2r_data,
        input p2r_valid,
        output p2r_ack
    );
    modport peer_end (
        input r2p_data,
        input r2p_valid,
        output r2p_ack,
        output p2r_data,
        output p2r_valid,
        input p2r_ack
    );
endinterface

// >>> mpr_link_end.sv
// peer end of a link: sends packets with check byte, receives and checks
`timescale 1ns/1ps
`include "mpr_consts.svh"
module mpr_link_end import mpr_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // link
    mpr_link_if.peer_end link,
    // user send side
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    // user receive side
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_last,
    input wire logic rx_ready,
    // status
    output logic boot_req
);
    // ***************
    // send path
    // ***************
    mpr_tx_state_t tx_st_reg, tx_st_next;
    logic [7:0] od_reg, od_next, tcrc_reg, tcrc_next;
    logic ov_reg, ov_next, trdy_reg, trdy_next;

    always_comb begin
        tx_st_next = tx_st_reg;
        od_next = od_reg;
        ov_next = ov_reg;
        tcrc_next = tcrc_reg;
        if (!ov_reg || link.p2r_ack) begin
            ov_next = 1'b0;
            if (tx_st_reg == TX_CRC) begin
                od_next = tcrc_reg;
                ov_next = 1'b1;
                tcrc_next = `MPR_CRC_INIT;
                tx_st_next = TX_DATA;
            end else if (tx_valid && trdy_reg) begin
                od_next = tx_data;
                ov_next = 1'b1;
                tcrc_next = mpr_crc_step(tcrc_reg, tx_data);
                if (tx_last) begin
                    tx_st_next = TX_CRC;
                end
            end
        end
        trdy_next = (tx_st_next == TX_DATA) && !ov_next;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_st_reg <= TX_DATA;
            od_reg <= 8'h00;
            ov_reg <= 1'b0;
            tcrc_reg <= `MPR_CRC_INIT;
            trdy_reg <= 1'b0;
        end else begin
            tx_st_reg <= tx_st_next;
            od_reg <= od_next;
            ov_reg <= ov_next;
            tcrc_reg <= tcrc_next;
            trdy_reg <= trdy_next;
        end
    end

    assign link.p2r_data = od_reg;
    assign link.p2r_valid = ov_reg;
    assign tx_ready = trdy_reg;

    // ***************
    // receive path
    // ***************
    logic [11:0] pos_reg, pos_next, end_pos;
    logic [9:0] len_reg, len_next;
    logic [7:0] rcrc_reg, rcrc_next, rd_reg, rd_next;
    logic ack_reg, ack_next, rv_reg, rv_next, rl_reg, rl_next, boot_reg, boot_next, take;

    assign take = link.r2p_valid && ack_reg;
    assign end_pos = `MPR_HDR_BYTES + {len_reg, 2'b00};

    always_comb begin
        pos_next = pos_reg;
        len_next = len_reg;
        rcrc_next = rcrc_reg;
        rd_next = rd_reg;
        rv_next = rv_reg && !rx_ready;
        rl_next = rl_reg;
        boot_next = boot_reg;
        if (take) begin
            rd_next = link.r2p_data;
            rv_next = 1'b1;
            rl_next = 1'b0;
            pos_next = pos_reg + 12'h001;
            if (pos_reg == `MPR_B_LEN_LO) begin
                len_next[7:0] = link.r2p_data;
            end
            if (pos_reg == `MPR_B_LEN_HI) begin
                len_next[9:8] = link.r2p_data[1:0];
            end
            if (pos_reg >= `MPR_HDR_BYTES && pos_reg == end_pos) begin
                if (rcrc_reg != link.r2p_data) begin
                    boot_next = 1'b1;
                end
                rl_next = 1'b1;
                pos_next = 12'h000;
                rcrc_next = `MPR_CRC_INIT;
            end else begin
                rcrc_next = mpr_crc_step(rcrc_reg, link.r2p_data);
            end
        end
        // ack only with free holding slot
        ack_next = !rv_next;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pos_reg <= 12'h000;
            len_reg <= 10'h000;
            rcrc_reg <= `MPR_CRC_INIT;
            rd_reg <= 8'h00;
            rv_reg <= 1'b0;
            rl_reg <= 1'b0;
            boot_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            len_reg <= len_next;
            rcrc_reg <= rcrc_next;
            rd_reg <= rd_next;
            rv_reg <= rv_next;
            rl_reg <= rl_next;
            boot_reg <= boot_next;
            ack_reg <= ack_next;
        end
    end

    assign link.r2p_ack = ack_reg;
    assign rx_data = rd_reg;
    assign rx_valid = rv_reg;
    assign rx_last = rl_reg;
    assign boot_req = boot_reg;
endmodule

// >>> mpr_router.sv
// mesh node router: dimension-order routing, cut-through output FIFOs
`timescale 1ns/1ps
`include "mpr_consts.svh"
module mpr_router import mpr_pkg::*; #(
    parameter int NCOL = 32,
    parameter int NROW = 32,
    parameter int FIFO_AW = 12
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // node position
    input wire logic [7:0] my_col,
    input wire logic [7:0] my_row,
    // neighbour links
    mpr_link_if.router_end link_e,
    mpr_link_if.router_end link_w,
    mpr_link_if.router_end link_n,
    mpr_link_if.router_end link_s,
    // local processor
    input wire logic [7:0] proc_tx_data,
    input wire logic proc_tx_valid,
    output logic proc_tx_ack,
    output logic [7:0] proc_rx_data,
    output logic proc_rx_valid,
    input wire logic proc_rx_ack,
    // diagnostic
    output logic [4:0] err_flags,
    input wire logic [4:0] err_clear
);
    localparam int NP = 5;
    localparam int DEPTH = 1 << FIFO_AW;
    localparam logic [8:0] NCOL_V = 9'(NCOL);
    localparam logic [7:0] LAST_ROW = 8'(NROW - 1);
    localparam logic [FIFO_AW:0] DEPTH_V = (FIFO_AW + 1)'(DEPTH);

    logic [7:0] in_data [NP];
    logic in_valid [NP];
    logic out_ack [NP];
    logic edge_term [NP];
    logic take [NP];
    logic [2:0] route [NP];
    logic push_req [NP];
    logic push_last [NP];
    logic [7:0] push_data [NP];
    logic [11:0] end_pos [NP];
    logic [NP-1:0] gnt [NP];
    logic room [NP];
    logic room_next [NP];
    logic [FIFO_AW:0] cnt_reg [NP];
    logic [FIFO_AW:0] cnt_next [NP];

    mpr_in_state_t st_reg [NP];
    mpr_in_state_t st_next [NP];
    logic [11:0] pos_reg [NP];
    logic [11:0] pos_next [NP];
    logic [9:0] len_reg [NP];
    logic [9:0] len_next [NP];
    logic [7:0] crc_reg [NP];
    logic [7:0] crc_next [NP];
    logic [2:0] rp_reg [NP];
    logic [2:0] rp_next [NP];
    logic [2:0] dest_reg [NP];
    logic [2:0] dest_next [NP];
    logic ack_reg [NP];
    logic ack_next [NP];
    logic err_reg [NP];
    logic err_next [NP];
    logic [7:0] hold_reg [NP][8];
    logic [7:0] hold_next [NP][8];

    logic [7:0] mem [NP][DEPTH];
    logic [FIFO_AW-1:0] wp_reg [NP];
    logic [FIFO_AW-1:0] wp_next [NP];
    logic [FIFO_AW-1:0] rd_reg [NP];
    logic [FIFO_AW-1:0] rd_next [NP];
    logic ov_reg [NP];
    logic ov_next [NP];
    logic [7:0] od_reg [NP];
    logic [7:0] od_next [NP];
    logic busy_reg [NP];
    logic busy_next [NP];
    logic [2:0] own_reg [NP];
    logic [2:0] own_next [NP];
    logic push [NP];

    // ***************
    // port mapping
    // ***************
    // four links plus processor port
    assign in_data = '{link_e.p2r_data, link_w.p2r_data, link_n.p2r_data, link_s.p2r_data, proc_tx_data};
    assign in_valid = '{link_e.p2r_valid, link_w.p2r_valid, link_n.p2r_valid, link_s.p2r_valid, proc_tx_valid};
    assign out_ack = '{link_e.r2p_ack, link_w.r2p_ack, link_n.r2p_ack, link_s.r2p_ack, proc_rx_ack};
    assign link_e.r2p_data = od_reg[0];
    assign link_w.r2p_data = od_reg[1];
    assign link_n.r2p_data = od_reg[2];
    assign link_s.r2p_data = od_reg[3];
    assign proc_rx_data = od_reg[4];
    assign link_e.r2p_valid = ov_reg[0];
    assign link_w.r2p_valid = ov_reg[1];
    assign link_n.r2p_valid = ov_reg[2];
    assign link_s.r2p_valid = ov_reg[3];
    assign proc_rx_valid = ov_reg[4];
    assign link_e.p2r_ack = ack_reg[0];
    assign link_w.p2r_ack = ack_reg[1];
    assign link_n.p2r_ack = ack_reg[2];
    assign link_s.p2r_ack = ack_reg[3];
    assign proc_tx_ack = ack_reg[4];
    assign err_flags = {err_reg[4], err_reg[3], err_reg[2], err_reg[1], err_reg[0]};
    assign edge_term = '{1'b0, 1'b0, my_row == 8'h00, my_row == LAST_ROW, 1'b0};

    // ***************
    // input ports
    // ***************
    for (genvar i = 0; i < NP; i++) begin : g_in
        assign take[i] = in_valid[i] && ack_reg[i];
        assign end_pos[i] = `MPR_HDR_BYTES + {len_reg[i], 2'b00};

        always_comb begin
            logic [8:0] d;
            logic [8:0] rem;
            logic [7:0] dcol;
            logic [7:0] drow;
            dcol = hold_reg[i][`MPR_B_COL];
            drow = hold_reg[i][`MPR_B_ROW];
            d = (dcol >= my_col) ? ({1'b0, dcol} - {1'b0, my_col}) : ({1'b0, dcol} + NCOL_V - {1'b0, my_col});
            rem = NCOL_V - d;
            if (d == 9'h000) begin
                if (drow == my_row) begin
                    route[i] = `MPR_P_LOCAL;
                end else if (drow > my_row) begin
                    route[i] = `MPR_P_SOUTH;
                end else begin
                    route[i] = `MPR_P_NORTH;
                end
            end else if (d < rem) begin
                route[i] = `MPR_P_EAST;
            end else if (d > rem) begin
                route[i] = `MPR_P_WEST;
            end else begin
                route[i] = my_col[0] ? `MPR_P_WEST : `MPR_P_EAST;
            end
        end

        always_comb begin
            logic gi;
            logic ack_n;
            gi = 1'b0;
            ack_n = 1'b0;
            for (int o = 0; o < NP; o++) begin
                gi = gi | gnt[o][i];
            end
            st_next[i] = st_reg[i];
            pos_next[i] = pos_reg[i];
            len_next[i] = len_reg[i];
            crc_next[i] = crc_reg[i];
            rp_next[i] = rp_reg[i];
            dest_next[i] = dest_reg[i];
            hold_next[i] = hold_reg[i];
            // sticky flag, set wins over clear
            err_next[i] = err_reg[i] && !err_clear[i];
            push_req[i] = 1'b0;
            push_last[i] = 1'b0;
            push_data[i] = in_data[i];
            case (st_reg[i])
                IN_HDR: begin
                    ack_n = 1'b1;
                    if (take[i]) begin
                        hold_next[i][pos_reg[i][2:0]] = in_data[i];
                        crc_next[i] = mpr_crc_step(crc_reg[i], in_data[i]);
                        pos_next[i] = pos_reg[i] + 12'h001;
                        if (pos_reg[i] == `MPR_B_LEN_LO) begin
                            len_next[i][7:0] = in_data[i];
                        end
                        if (pos_reg[i] == `MPR_B_LEN_HI) begin
                            len_next[i][9:8] = in_data[i][1:0];
                        end
                        if (pos_reg[i][2:0] == `MPR_HDR_LAST) begin
                            st_next[i] = IN_REQ;
                            ack_n = 1'b0;
                        end
                    end
                end
                IN_REQ: begin
                    if (gi) begin
                        st_next[i] = IN_REPLAY;
                        rp_next[i] = 3'h0;
                        dest_next[i] = route[i];
                    end
                end
                IN_REPLAY: begin
                    push_data[i] = hold_reg[i][rp_reg[i]];
                    if (room[dest_reg[i]]) begin
                        push_req[i] = 1'b1;
                        rp_next[i] = rp_reg[i] + 3'h1;
                        if (rp_reg[i] == `MPR_HDR_LAST) begin
                            st_next[i] = IN_BODY;
                            ack_n = room_next[dest_reg[i]];
                        end
                    end
                end
                IN_BODY: begin
                    ack_n = room_next[dest_reg[i]];
                    if (take[i]) begin
                        push_req[i] = 1'b1;
                        pos_next[i] = pos_reg[i] + 12'h001;
                        if (pos_reg[i] == end_pos[i]) begin
                            push_last[i] = 1'b1;
                            if (crc_reg[i] != in_data[i]) begin
                                err_next[i] = 1'b1;
                            end
                            st_next[i] = IN_HDR;
                            pos_next[i] = 12'h000;
                            crc_next[i] = `MPR_CRC_INIT;
                            ack_n = 1'b1;
                        end else begin
                            crc_next[i] = mpr_crc_step(crc_reg[i], in_data[i]);
                        end
                    end
                end
                default: begin
                    st_next[i] = IN_HDR;
                end
            endcase
            ack_next[i] = ack_n && !edge_term[i];
        end

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                st_reg[i] <= IN_HDR;
                pos_reg[i] <= 12'h000;
                len_reg[i] <= 10'h000;
                crc_reg[i] <= `MPR_CRC_INIT;
                rp_reg[i] <= 3'h0;
                dest_reg[i] <= 3'h0;
                ack_reg[i] <= 1'b0;
                err_reg[i] <= 1'b0;
                hold_reg[i] <= '{default: 8'h00};
            end else begin
                st_reg[i] <= st_next[i];
                pos_reg[i] <= pos_next[i];
                len_reg[i] <= len_next[i];
                crc_reg[i] <= crc_next[i];
                rp_reg[i] <= rp_next[i];
                dest_reg[i] <= dest_next[i];
                ack_reg[i] <= ack_next[i];
                err_reg[i] <= err_next[i];
                hold_reg[i] <= hold_next[i];
            end
        end
    end

    // ***************
    // output FIFOs
    // ***************
    for (genvar o = 0; o < NP; o++) begin : g_out
        // lowest index wins: ring before local
        always_comb begin
            logic found;
            logic inj_ok;
            found = 1'b0;
            inj_ok = 1'b0;
            gnt[o] = '0;
            for (int i = 0; i < NP; i++) begin
                inj_ok = (3'(i) != `MPR_P_LOCAL) || (3'(o) >= `MPR_P_NORTH)
                    || ((DEPTH_V - cnt_reg[o]) > {1'b0, end_pos[i] + 12'h001});
                if (!busy_reg[o] && !found && st_reg[i] == IN_REQ && route[i] == 3'(o) && inj_ok) begin
                    gnt[o][i] = 1'b1;
                    found = 1'b1;
                end
            end
        end

        always_comb begin
            logic pop;
            pop = (cnt_reg[o] != '0) && (!ov_reg[o] || out_ack[o]);
            push[o] = busy_reg[o] && push_req[own_reg[o]];
            cnt_next[o] = cnt_reg[o] + (FIFO_AW + 1)'(push[o]) - (FIFO_AW + 1)'(pop);
            room[o] = cnt_reg[o] < DEPTH_V;
            room_next[o] = cnt_next[o] < DEPTH_V;
            wp_next[o] = push[o] ? wp_reg[o] + 1'b1 : wp_reg[o];
            rd_next[o] = pop ? rd_reg[o] + 1'b1 : rd_reg[o];
            // head loads the cycle after entry
            ov_next[o] = pop || (ov_reg[o] && !out_ack[o]);
            od_next[o] = pop ? mem[o][rd_reg[o]] : od_reg[o];
            busy_next[o] = busy_reg[o];
            own_next[o] = own_reg[o];
            if (push[o] && push_last[own_reg[o]]) begin
                busy_next[o] = 1'b0;
            end
            for (int i = 0; i < NP; i++) begin
                if (gnt[o][i]) begin
                    busy_next[o] = 1'b1;
                    own_next[o] = 3'(i);
                end
            end
        end

        always_ff @(posedge ref_clk) begin
            if (push[o]) begin
                mem[o][wp_reg[o]] <= push_data[own_reg[o]];
            end
            if (reset) begin
                cnt_reg[o] <= '0;
                wp_reg[o] <= '0;
                rd_reg[o] <= '0;
                ov_reg[o] <= 1'b0;
                od_reg[o] <= 8'h00;
                busy_reg[o] <= 1'b0;
                own_reg[o] <= 3'h0;
            end else begin
                cnt_reg[o] <= cnt_next[o];
                wp_reg[o] <= wp_next[o];
                rd_reg[o] <= rd_next[o];
                ov_reg[o] <= ov_next[o];
                od_reg[o] <= od_next[o];
                busy_reg[o] <= busy_next[o];
                own_reg[o] <= own_next[o];
            end
        end
    end
endmodule

// >>> mpr_link_chk.sv
// assertions on the east link between router and peer end
`timescale 1ns/1ps
module mpr_link_chk import mpr_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // link signals
    input wire logic [7:0] r2p_data,
    input wire logic r2p_valid,
    input wire logic r2p_ack,
    input wire logic [7:0] p2r_data,
    input wire logic p2r_valid,
    input wire logic p2r_ack
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ****************
    // link properties
    // ****************
    out_hold_a: assert property (r2p_valid && !r2p_ack |=> r2p_valid)
        else $error("router dropped an unacknowledged byte");
    data_hold_a: assert property (r2p_valid && !r2p_ack |=> $stable(r2p_data))
        else $error("router changed an unacknowledged byte");
    in_hold_a: assert property (p2r_valid && !p2r_ack |=> p2r_valid && $stable(p2r_data))
        else $error("peer did not hold its byte");
    quiet_reset_a: assert property (disable iff (1'b0) reset |=> !r2p_valid && !r2p_ack && !p2r_valid && !p2r_ack)
        else $error("link not quiet after reset");
    ack_start_a: assert property ($fell(reset) |-> !p2r_ack && !r2p_ack ##[1:2] p2r_ack && r2p_ack)
        else $error("acks not raised after reset");
    peer_take_a: assert property (r2p_valid && r2p_ack |=> !r2p_ack)
        else $error("peer ack stayed high with a full slot");
    peer_back_a: assert property ($fell(r2p_ack) |-> ##[1:100] r2p_ack)
        else $error("peer ack stuck low");
    in_back_a: assert property ($fell(p2r_ack) |-> ##[1:300] p2r_ack)
        else $error("router input ack stuck low");
    cover property (r2p_valid && !r2p_ack ##1 r2p_valid && r2p_ack);
    cover property (p2r_valid && p2r_ack);
    cover property ($fell(p2r_ack));
endmodule

// >>> test_mpr_router.sv
// self-checking bench for the router with a peer end on every link
`timescale 1ns/1ps
module test_mpr_router import mpr_pkg::*;;
    typedef logic [7:0] mpr_bq_t [$];
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0][7:0] tx_data = '0;
    logic [3:0] tx_valid = 4'h0;
    logic [3:0] tx_last = 4'h0;
    logic [3:0] tx_ready;
    logic [3:0][7:0] rx_data;
    logic [3:0] rx_valid;
    logic [3:0] rx_ready = 4'hF;
    logic [3:0] boot_req;
    logic [7:0] p_data = 8'h00;
    logic p_valid = 1'b0;
    logic p_ack;
    logic [7:0] q_data;
    logic q_valid;
    logic q_ack = 1'b1;
    logic [4:0] err_flags;
    logic [4:0] err_clear = 5'h00;
    logic [7:0] my_col = 8'h01;
    logic [7:0] my_row = 8'h01;
    logic [7:0] rq [5][$];
    int failures = 0;
    int n_tests = 0;
    int tbl [8][4] = '{'{4,2,1,0}, '{4,3,1,1}, '{4,0,1,1}, '{1,1,2,3}, '{0,1,0,2}, '{2,1,3,3}, '{3,1,1,4}, '{1,2,1,0}};
    // ****************
    // design and checker
    // ****************
    mpr_link_if lk[4] ();
    mpr_router #(.NCOL(4), .NROW(4), .FIFO_AW(6)) i_mpr_router (.ref_clk(ref_clk), .reset(reset),
        .my_col(my_col), .my_row(my_row), .link_e(lk[0]), .link_w(lk[1]), .link_n(lk[2]), .link_s(lk[3]),
        .proc_tx_data(p_data), .proc_tx_valid(p_valid), .proc_tx_ack(p_ack), .proc_rx_data(q_data),
        .proc_rx_valid(q_valid), .proc_rx_ack(q_ack), .err_flags(err_flags), .err_clear(err_clear));
    for (genvar k = 0; k < 4; k++) begin : g_end
        mpr_link_end i_mpr_link_end (.ref_clk(ref_clk), .reset(reset), .link(lk[k]), .tx_data(tx_data[k]),
            .tx_valid(tx_valid[k]), .tx_last(tx_last[k]), .tx_ready(tx_ready[k]), .rx_data(rx_data[k]),
            .rx_valid(rx_valid[k]), .rx_last(), .rx_ready(rx_ready[k]), .boot_req(boot_req[k]));
    end
    mpr_link_chk i_mpr_link_chk (.ref_clk(ref_clk), .reset(reset), .r2p_data(lk[0].r2p_data),
        .r2p_valid(lk[0].r2p_valid), .r2p_ack(lk[0].r2p_ack), .p2r_data(lk[0].p2r_data),
        .p2r_valid(lk[0].p2r_valid), .p2r_ack(lk[0].p2r_ack));
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        for (int k = 0; k < 4; k++) begin
            if (rx_valid[k] && rx_ready[k])
                rq[k].push_back(rx_data[k]);
        end
        if (q_valid && q_ack)
            rq[4].push_back(q_data);
    end
    // ****************
    // helpers
    // ****************
    function automatic logic [7:0] crc8(input mpr_bq_t q);
        logic [7:0] c;
        c = 8'h00;
        foreach (q[i]) begin
            c = c ^ q[i];
            for (int b = 0; b < 8; b++) begin
                c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction
    function automatic mpr_bq_t make_pkt(input logic [7:0] c, input logic [7:0] r, input logic [7:0] t, input int n);
        mpr_bq_t q;
        q = '{c, r, t, 8'h00, 8'(n), 8'(n >> 8), 8'h00, 8'h00};
        for (int i = 0; i < 4 * n; i++) begin
            q.push_back(8'(i * 3) ^ t);
        end
        return q;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send_byte(input int k, input logic [7:0] b, input logic last);
        int t;
        t = 0;
        if (k == 4) begin
            p_data <= b;
            p_valid <= 1'b1;
        end else begin
            tx_data[k] <= b;
            tx_valid[k] <= 1'b1;
            tx_last[k] <= last;
        end
        do begin
            @(negedge ref_clk);
            t++;
        end while (!((k == 4) ? p_ack : tx_ready[k]) && t < 300);
        check(16'((k == 4) ? p_ack : tx_ready[k]), 16'h0001);
        @(posedge ref_clk);
    endtask
    task automatic send_pkt(input int k, input mpr_bq_t q, input logic [7:0] bad);
        for (int i = 0; i < q.size(); i++) begin
            send_byte(k, q[i], i == q.size() - 1);
        end
        if (k == 4) begin
            send_byte(4, crc8(q) ^ bad, 1'b1);
            p_valid <= 1'b0;
        end else begin
            tx_valid[k] <= 1'b0;
            tx_last[k] <= 1'b0;
        end
        @(posedge ref_clk);
    endtask
    task automatic expect_pkt(input int d, input mpr_bq_t q, input logic [7:0] bad);
        int t;
        t = 0;
        while (rq[d].size() <= q.size() && t < 600) begin
            @(posedge ref_clk);
            t++;
        end
        check(16'(rq[d].size()), 16'(q.size() + 1));
        foreach (q[i]) begin
            check(16'(rq[d][i]), 16'(q[i]));
        end
        check(16'(rq[d][q.size()]), 16'(crc8(q) ^ bad));
        rq[d].delete();
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        #300000;
        failures++;
        report_and_stop();
    end
    initial begin
        mpr_bq_t p;
        mpr_bq_t p2;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            p = make_pkt(8'(tbl[i][1]), 8'(tbl[i][2]), 8'(i * 37), (i * 5) % 13);
            send_pkt(tbl[i][0], p, 8'h00);
            expect_pkt(tbl[i][3], p, 8'h00);
        end
        for (int k = 0; k < 5; k++) begin
            check(16'(rq[k].size()), 16'h0000);
        end
        p = make_pkt(8'h01, 8'h02, 8'h3C, 12);
        p2 = make_pkt(8'h02, 8'h01, 8'hC3, 12);
        rx_ready[0] <= 1'b0;
        fork
            send_pkt(1, p, 8'h00);
            send_pkt(4, p2, 8'h00);
            begin
                repeat (40) @(posedge ref_clk);
                rx_ready[0] <= 1'b1;
            end
        join
        expect_pkt(3, p, 8'h00);
        expect_pkt(0, p2, 8'h00);
        p = make_pkt(8'h02, 8'h01, 8'h11, 1);
        send_pkt(4, p, 8'h5A);
        expect_pkt(0, p, 8'h5A);
        repeat (20) @(posedge ref_clk);
        check(16'(err_flags), 16'h0010);
        check(16'(boot_req), 16'h0001);
        err_clear <= 5'h10;
        @(posedge ref_clk);
        err_clear <= 5'h00;
        repeat (2) @(posedge ref_clk);
        check(16'(err_flags), 16'h0000);
        my_col <= 8'h02;
        my_row <= 8'h00;
        repeat (2) @(posedge ref_clk);
        check(16'(lk[2].p2r_ack), 16'h0000);
        p = make_pkt(8'h00, 8'h00, 8'h5C, 2);
        send_pkt(4, p, 8'h00);
        expect_pkt(0, p, 8'h00);
        report_and_stop();
    end
endmodule
